// ==== pkg/ssmt_pkg.sv ====
// package: register map, field positions and bit counts for the synchronous master transmitter
package ssmt_pkg;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_BAUD    = 8'h08;
    localparam logic [7:0] ADDR_TX_HOLD = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
    localparam logic [7:0] ADDR_MASK    = 8'h1f;

    // transmit_control_status bit positions
    localparam int TXC_MASTER    = 7;
    localparam int TXC_NINE      = 6;
    localparam int TXC_TRANSMIT_ENABLE      = 5;
    localparam int TXC_SYNC      = 4;
    localparam int TXC_HIGHSPEED = 2;
    localparam int TXC_IDLE      = 1;
    localparam int TXC_NINTH     = 0;
    // receive_control_status bit positions
    localparam int RXC_SERIAL_PORT_ENABLE      = 7;
    localparam int RXC_SINGLE_RECEIVE_ENABLE      = 5;
    localparam int RXC_CONTINUOUS_RECEIVE_ENABLE      = 4;
    // interrupt enable bits (stored only)
    localparam int IRQ_GIE       = 7;
    localparam int IRQ_PERIPHERAL_INTERRUPT_ENABLE      = 6;
    localparam int IRQ_TRANSMIT_INTERRUPT_ENABLE      = 4;

    localparam logic [7:0] TXC_RESET = 8'h02;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    localparam int DATA_BITS = 8;
    localparam int CHAR_BITS_MAX = 9;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE  = 4'h9;

    typedef struct packed {
        logic master;
        logic nine;
        logic transmit_enable;
        logic sync;
        logic high_speed;
        logic ninth_bit;
    } ssmt_cfg_t;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic dat_o;
        logic dat_oe;
    } ssmt_pins_t;
endpackage

// ==== rtl/ssmt_baud_gen.sv ====
// baud divider: one-cycle tick at every half period of the shift clock
`timescale 1ns/1ps
module ssmt_baud_gen #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             high_speed,
    // tick
    output logic                  tick
);
    // half period = (divisor+1) cycles, doubled when not in high-speed
    logic [DIV_W:0] cnt_q;
    logic [DIV_W:0] cnt_d;
    logic [DIV_W:0] limit;
    logic           hit;

    assign limit = high_speed ? {1'b0, divisor} : {divisor, 1'b1};
    assign hit   = run && (cnt_q >= limit);
    assign cnt_d = (!run || hit) ? '0 : cnt_q + 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= hit;
        end
    end
endmodule

// ==== rtl/ssmt_top.sv ====
// synchronous master transmitter with ahb-lite register slave
// Functional notes
// RULE1 - sync select set: clocked operation with clock line and two-way data line.
// RULE2 - master select set in sync mode: unit generates shift clock itself.
// RULE3 - transmit mode only while both receive enables are clear.
// RULE4 - unit active only while serial port enable is set.
// RULE5 - master drives clock pin; clock driver enabled in sync master mode.
// RULE6 - transmit drives data pin; data and clock drivers enabled.
// RULE7 - data changes on leading clock edge, stable at trailing edge.
// RULE8 - each bit holds from one leading edge to the next.
// RULE9 - exactly one clock cycle per data bit, no extra clocks.
// RULE10 - no start or stop bits, only data bits on the line.
// RULE11 - half duplex: never transmit while receive is selected.
// RULE12 - writing the holding register starts a transmission.
// RULE13 - new character waits in holding register until shifter finishes.
// RULE14 - idle shifter takes held character at once and starts shifting.
// RULE15 - shift register is not in the software map.
// RULE16 - software sets transmit enable after configuring master mode.
// RULE17 - nine-bit select sends ninth bit from its control field.
// RULE18 - software programs baud first, then mode bits, then clears receive.
// RULE19 - software enables interrupts if wanted; loading holding starts sending.
// RULE20 - shift clock period set by baud divisor and high-speed select.
// RULE21 - least significant bit first, ninth bit last.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module ssmt_top #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link pins
    input  wire logic        clk_line_i,
    input  wire logic        data_line_i,
    output logic             clk_line_o,
    output logic             clk_line_oe,
    output logic             data_line_o,
    output logic             data_line_oe
);
    typedef enum logic [1:0] {S_IDLE, S_LEAD, S_TRAIL} ssmt_state_t;

    // registers
    logic [7:0] txc_q;
    logic [7:0] rxc_q;
    logic [7:0] baud_q;
    logic [7:0] irq_q;
    logic [7:0] hold_q;
    logic       hold_ninth_q;
    logic       hold_full_q;

    // hidden shift register, never decoded on the bus
    logic [ssmt_pkg::CHAR_BITS_MAX-1:0] shift_q; // RULE15
    logic [3:0]  left_q;
    ssmt_state_t state_q;
    logic        sclk_q;

    // pin sampling (no logic reads the second stage)
    logic [1:0] clk_sync_q;
    logic [1:0] dat_sync_q;

    // ahb address phase capture
    logic       wr_pend_q;
    logic [7:0] addr_q;

    ssmt_pkg::ssmt_cfg_t cfg;
    assign cfg = '{master:     txc_q[ssmt_pkg::TXC_MASTER],
                   nine:       txc_q[ssmt_pkg::TXC_NINE],
                   transmit_enable:       txc_q[ssmt_pkg::TXC_TRANSMIT_ENABLE],
                   sync:       txc_q[ssmt_pkg::TXC_SYNC],
                   high_speed: txc_q[ssmt_pkg::TXC_HIGHSPEED],
                   ninth_bit:  txc_q[ssmt_pkg::TXC_NINTH]};

    // mode decode
    logic port_on;
    logic master_on;
    logic rx_sel;
    logic tx_mode;
    logic tx_run;
    assign port_on   = rxc_q[ssmt_pkg::RXC_SERIAL_PORT_ENABLE];                   // RULE4
    assign master_on = port_on && cfg.sync && cfg.master;           // RULE1 RULE2
    assign rx_sel    = rxc_q[ssmt_pkg::RXC_SINGLE_RECEIVE_ENABLE] | rxc_q[ssmt_pkg::RXC_CONTINUOUS_RECEIVE_ENABLE];
    assign tx_mode   = master_on && !rx_sel;                        // RULE3 RULE11
    assign tx_run    = tx_mode && cfg.transmit_enable;

    // baud ticks mark half periods of the shift clock
    logic tick;
    logic baud_run;
    ssmt_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (baud_run),
        .divisor    (baud_q[DIV_W-1:0]),
        .high_speed (cfg.high_speed),
        .tick       (tick)                                          // RULE20
    );

    // bus decode
    logic       addr_ok;
    logic       wr_go;
    logic       hold_wr;
    logic       load;
    logic       shifting;
    logic       last_bit;
    logic [7:0] bus_addr;
    assign addr_ok  = hsel && hready && htrans == ssmt_pkg::HTRANS_NONSEQ;
    assign bus_addr = haddr[7:0] & ssmt_pkg::ADDR_MASK;
    assign wr_go    = wr_pend_q;
    assign hold_wr  = wr_go && addr_q == ssmt_pkg::ADDR_TX_HOLD;    // RULE12
    assign shifting = state_q != S_IDLE;
    assign last_bit = state_q == S_TRAIL && tick && left_q == 4'h1;
    // shifter empty or finishing: take held character at once
    assign load     = tx_run && hold_full_q && (!shifting || last_bit); // RULE13 RULE14
    // divider counts from the load cycle so the first half matches the rest, except one cycle short for a load the cycle after a character ends
    assign baud_run = tx_run && (shifting || load);                 // RULE20

    logic idle_flag;
    assign idle_flag = !shifting;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (bus_addr)
            ssmt_pkg::ADDR_TX_CTRL: rd_mux[7:0] = {txc_q[7:2], idle_flag, txc_q[0]};
            ssmt_pkg::ADDR_RX_CTRL: rd_mux[7:0] = rxc_q;
            ssmt_pkg::ADDR_BAUD:    rd_mux[7:0] = baud_q;
            ssmt_pkg::ADDR_STATUS:  rd_mux[1:0] = {hold_full_q, shifting};
            ssmt_pkg::ADDR_IRQ_EN:  rd_mux[7:0] = irq_q;
            default:                rd_mux      = '0;
        endcase
    end

    // bus capture and read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            addr_q    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok) begin
                addr_q <= bus_addr;
            end
            // read data taken at the address phase so it stands through the data phase
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // software registers; the idle bit of control is read-only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txc_q  <= ssmt_pkg::TXC_RESET;
            rxc_q  <= '0;
            baud_q <= '0;
            irq_q  <= '0;
        end else if (wr_go) begin
            if (addr_q == ssmt_pkg::ADDR_TX_CTRL) txc_q <= hwdata[7:0];
            if (addr_q == ssmt_pkg::ADDR_RX_CTRL) rxc_q <= hwdata[7:0];
            if (addr_q == ssmt_pkg::ADDR_BAUD)    baud_q <= hwdata[7:0];
            if (addr_q == ssmt_pkg::ADDR_IRQ_EN)  irq_q <= hwdata[7:0];
        end
    end

    // holding register: a write in the cycle it is emptied still lands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q       <= '0;
            hold_ninth_q <= 1'b0;
            hold_full_q  <= 1'b0;
        end else if (!port_on) begin
            hold_full_q  <= 1'b0;
        end else if (hold_wr) begin
            hold_q       <= hwdata[7:0];
            hold_ninth_q <= cfg.ninth_bit;                          // RULE17
            hold_full_q  <= 1'b1;
        end else if (load) begin
            hold_full_q  <= 1'b0;
        end
    end

    // shifter: data moves at the leading (rising) edge, held through the trailing edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            shift_q <= '0;
            left_q  <= '0;
            sclk_q  <= 1'b0;
        end else if (!tx_run) begin
            state_q <= S_IDLE;
            sclk_q  <= 1'b0;
        end else if (load) begin
            // lsb first, ninth bit last, no framing bits
            shift_q <= {hold_ninth_q, hold_q};                      // RULE10 RULE21
            left_q  <= cfg.nine ? ssmt_pkg::BITS_NINE : ssmt_pkg::BITS_EIGHT; // RULE17
            state_q <= S_LEAD;
            sclk_q  <= 1'b1;                                        // RULE7
        end else if (tick && state_q == S_LEAD) begin
            state_q <= S_TRAIL;
            sclk_q  <= 1'b0;
        end else if (tick && state_q == S_TRAIL) begin
            left_q  <= left_q - 1'b1;                               // RULE9
            if (left_q == 4'h1) begin
                state_q <= S_IDLE;
            end else begin
                shift_q <= shift_q >> 1;                            // RULE8
                state_q <= S_LEAD;
                sclk_q  <= 1'b1;
            end
        end
    end

    // pin outputs from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_line_o   <= 1'b0;
            clk_line_oe  <= 1'b0;
            data_line_o  <= 1'b0;
            data_line_oe <= 1'b0;
            clk_sync_q   <= '0;
            dat_sync_q   <= '0;
        end else begin
            clk_line_o   <= sclk_q;                                 // RULE5
            clk_line_oe  <= master_on;                              // RULE5
            data_line_o  <= shift_q[0];                             // RULE6
            data_line_oe <= tx_mode;                                // RULE6 RULE11
            clk_sync_q   <= {clk_sync_q[0], clk_line_i};
            dat_sync_q   <= {dat_sync_q[0], data_line_i};
        end
    end

    // assertions
    a_no_drive_rx: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
        rx_sel |=> !data_line_oe) else $error("data driven in receive");
    a_off_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        !port_on |=> !clk_line_oe) else $error("clock driven while off");
    a_hold_stable: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        (state_q == S_TRAIL && !tick) |=> $stable(shift_q[0])) else $error("data moved mid bit");
    a_load_start: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        load |=> state_q == S_LEAD && sclk_q) else $error("load did not start");
    a_wait_busy: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        (hold_full_q && state_q == S_LEAD && tx_run && !hold_wr) |=> hold_full_q)
        else $error("held char lost");
    a_bit_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        load |=> left_q == (cfg.nine ? ssmt_pkg::BITS_NINE : ssmt_pkg::BITS_EIGHT))
        else $error("bad bit count");
    a_write_holds: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        (hold_wr && port_on) |=> hold_full_q || shifting) else $error("write lost");
    a_clk_low_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        (state_q == S_IDLE) |-> !sclk_q) else $error("clock pulse when idle");
    a_pin_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        master_on |=> clk_line_oe) else $error("clock driver off");
    c_load: cover property (@(posedge clk) disable iff (!rst_n) load);
    c_back: cover property (@(posedge clk) disable iff (!rst_n) load && shifting);
    c_nine: cover property (@(posedge clk) disable iff (!rst_n) load && cfg.nine);
endmodule

// ==== tb/ssmt_slave_model.sv ====
// slave model: takes the master clock and samples data at each trailing edge
`timescale 1ns/1ps
module ssmt_slave_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // link wires
    input  wire logic sclk,
    input  wire logic sdat,
    input  wire logic sdat_oe,
    input  wire logic clr,
    // observations
    output logic        dat_drv,
    output logic [17:0] sr_q,
    output logic [5:0]  cnt_q,
    output logic [7:0]  hi_q,
    output logic        bad_q
);
    logic       clk_q;
    logic       dat_q;
    logic [7:0] run_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {clk_q, dat_q, dat_drv, sr_q, cnt_q, hi_q, run_q, bad_q} <= '0;
        end else begin
            clk_q   <= sclk;
            dat_q   <= sdat;
            // slave never drives: the released line shows a changing pattern
            dat_drv <= ~dat_drv;
            run_q   <= sclk ? run_q + 8'h01 : 8'h00;
            // data may only move together with a rising clock
            if (sdat_oe && !(!clk_q && sclk) && sdat != dat_q) begin
                bad_q <= 1'b1;
            end
            if (clr) begin
                cnt_q <= 6'h00;
                bad_q <= 1'b0;
            end else if (clk_q && !sclk) begin
                sr_q  <= {dat_q, sr_q[17:1]};
                cnt_q <= cnt_q + 6'h01;
                hi_q  <= run_q;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
// testbench: register setup and character transfers against the slave model
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] MS = 32'h0000_0001 << ssmt_pkg::TXC_MASTER;
    localparam logic [31:0] SY = 32'h0000_0001 << ssmt_pkg::TXC_SYNC;
    localparam logic [31:0] TE = 32'h0000_0001 << ssmt_pkg::TXC_TRANSMIT_ENABLE;
    localparam logic [31:0] HS = 32'h0000_0001 << ssmt_pkg::TXC_HIGHSPEED;
    localparam logic [31:0] PE = 32'h0000_0001 << ssmt_pkg::RXC_SERIAL_PORT_ENABLE;
    localparam logic [31:0] IE = (32'h0000_0001 << ssmt_pkg::IRQ_GIE) | (32'h0000_0001 << ssmt_pkg::IRQ_PERIPHERAL_INTERRUPT_ENABLE)
                                 | (32'h0000_0001 << ssmt_pkg::IRQ_TRANSMIT_INTERRUPT_ENABLE);
    logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, clr;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        clk_line_i, data_line_i, clk_line_o, clk_line_oe;
    logic        data_line_o, data_line_oe, dat_drv, bad_q;
    logic [17:0] sr_q;
    logic [5:0]  cnt_q;
    logic [7:0]  hi_q;
    int          errors, check_count;

    assign hready      = hreadyout;
    assign clk_line_i  = clk_line_oe ? clk_line_o : dat_drv;
    assign data_line_i = data_line_oe ? data_line_o : dat_drv;

    ssmt_top ssmt_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .clk_line_i(clk_line_i), .data_line_i(data_line_i),
        .clk_line_o(clk_line_o), .clk_line_oe(clk_line_oe), .data_line_o(data_line_o),
        .data_line_oe(data_line_oe));
    ssmt_slave_model ssmt_slave_model_i (.clk(clk), .rst_n(rst_n), .sclk(clk_line_o),
        .sdat(data_line_o), .sdat_oe(data_line_oe), .clr(clr), .dat_drv(dat_drv), .sr_q(sr_q),
        .cnt_q(cnt_q), .hi_q(hi_q), .bad_q(bad_q));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= ssmt_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        hsize  <= ssmt_pkg::HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask

    task automatic idle();
        for (int i = 0; i < 100; i++) begin
            bus(1'b0, ssmt_pkg::ADDR_STATUS, 32'h0000_0000);
            if (rv === 32'h0000_0000) break;
        end
        check(rv, 32'h0000_0000);
    endtask

    task automatic pulse_clr();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
    endtask

    task automatic t_reset();
        bus(1'b0, ssmt_pkg::ADDR_TX_CTRL, 32'h0);
        check(rv, {24'h00_0000, ssmt_pkg::TXC_RESET});
        bus(1'b0, 8'h18, 32'h0);
        check(rv, 32'h0000_0000);
        check(clk_line_oe, 1'b0);
        check(hresp, 1'b0);
    endtask

    task automatic t_char(input logic [7:0] div, input logic [31:0] hs, input logic [7:0] half);
        bus(1'b1, ssmt_pkg::ADDR_BAUD, {24'h00_0000, div});
        bus(1'b1, ssmt_pkg::ADDR_TX_CTRL, hs);
        bus(1'b1, ssmt_pkg::ADDR_RX_CTRL, PE);
        bus(1'b1, ssmt_pkg::ADDR_TX_CTRL, hs | MS | SY | TE);
        bus(1'b0, ssmt_pkg::ADDR_TX_CTRL, 32'h0);
        check(rv, hs | MS | SY | TE | {24'h00_0000, ssmt_pkg::TXC_RESET});
        bus(1'b1, ssmt_pkg::ADDR_IRQ_EN, IE);
        bus(1'b0, ssmt_pkg::ADDR_IRQ_EN, 32'h0);
        check(rv, IE);
        pulse_clr();
        bus(1'b1, ssmt_pkg::ADDR_TX_HOLD, 32'h0000_00a5);
        check(clk_line_oe, 1'b1);
        check(data_line_oe, 1'b1);
        bus(1'b0, ssmt_pkg::ADDR_TX_HOLD, 32'h0);
        check(rv, 32'h0000_0000);
        idle();
        check(cnt_q, 6'h08);
        check(sr_q >> 10, 18'h0_00a5);
        check(bad_q, 1'b0);
        check(hi_q, half);
    endtask

    task automatic t_b2b();
        pulse_clr();
        bus(1'b1, ssmt_pkg::ADDR_TX_HOLD, 32'h0000_003c);
        bus(1'b1, ssmt_pkg::ADDR_TX_HOLD, 32'h0000_00c3);
        idle();
        check(cnt_q, 6'h10);
        check(sr_q >> 2, 18'h0_c33c);
    endtask

    task automatic t_nine();
        bus(1'b1, ssmt_pkg::ADDR_TX_CTRL, MS | SY | TE | 32'h0000_0041);
        pulse_clr();
        bus(1'b1, ssmt_pkg::ADDR_TX_HOLD, 32'h0000_0055);
        idle();
        check(cnt_q, 6'h09);
        check(sr_q >> 9, 18'h0_0155);
    endtask

    task automatic t_rx(input logic [31:0] rx);
        bus(1'b1, ssmt_pkg::ADDR_RX_CTRL, PE | rx);
        pulse_clr();
        bus(1'b1, ssmt_pkg::ADDR_TX_HOLD, 32'h0000_00ff);
        repeat (40) @(posedge clk);
        check(data_line_oe, 1'b0);
        check(clk_line_oe, 1'b1);
        check(cnt_q, 6'h00);
    endtask

    task automatic t_off(input logic [31:0] rx, input logic [31:0] tx);
        bus(1'b1, ssmt_pkg::ADDR_RX_CTRL, rx);
        bus(1'b1, ssmt_pkg::ADDR_TX_CTRL, tx);
        repeat (3) @(posedge clk);
        check(clk_line_oe, 1'b0);
        check(data_line_oe, 1'b0);
    endtask

    task automatic complete_run();
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        {rst_n, hsel, hwrite, clr, haddr, hwdata, htrans, hsize} = '0;
        errors      = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_char(8'h02, HS, 8'h03);
        t_char(8'h01, 32'h0, 8'h04);
        t_b2b();
        t_nine();
        t_rx(32'h0000_0020);
        t_rx(32'h0000_0010);
        t_off(32'h0, MS | SY | TE);
        t_off(PE, MS | TE);
        t_off(PE, SY | TE);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule
